//--- risc14_cfg.svh
// Constants for the 14-bit instruction decoder: offsets, fields, resets, timing
`ifndef RISC14_CFG_SVH
`define RISC14_CFG_SVH

// ----------------------------------------------------------------------------
// Register bus offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_ACC 4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_RUN_BIT 0
`define CTRL_PSA_BIT 1
`define CTRL_WAKE_BIT 2

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define ST_C_BIT 16
`define ST_DC_BIT 17
`define ST_Z_BIT 18
`define ST_TO_BIT 19
`define ST_PD_BIT 20
`define ST_MODE_LSB 21

// ----------------------------------------------------------------------------
// Instruction word groups and fixed words
// ----------------------------------------------------------------------------
`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define GRP_JUMP 2'h2
`define GRP_LIT 2'h3
`define W_RETURN 14'h0008
`define W_RETURN_FROM_HANDLER 14'h0009
`define W_SLEEP 14'h0063
`define W_KICK_WATCHDOG 14'h0064
`define W_CLRW 14'h0103

// ----------------------------------------------------------------------------
// File addresses with side effects
// ----------------------------------------------------------------------------
`define FA_TIMER0 7'h01
`define FA_PORT 7'h06

// ----------------------------------------------------------------------------
// Timing: oscillator periods per instruction cycle, last phase executes
// ----------------------------------------------------------------------------
`define OSC_PER_CYCLE 4
`define PHASE_EXEC 2'h3

// ----------------------------------------------------------------------------
// Bus responses and reset values
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_PC 13'h0000

`endif

//--- risc14_pkg.sv
// Types for the 14-bit instruction decoder
package risc14_pkg;

    typedef enum logic [1:0] {
        MODE_HALT = 2'b00,
        MODE_RUN = 2'b01,
        MODE_STANDBY = 2'b10
    } core_mode_t;

    typedef struct packed {
        logic [1:0] phase;
        logic [12:0] pc;
        logic [7:0] acc;
        logic [127:0][7:0] fregs;
        logic [7:0][12:0] stack;
        logic [2:0] sp;
        logic c;
        logic dc;
        logic z;
        logic to;
        logic pd;
        logic nop_next;
        core_mode_t mode;
        logic psa;
        logic wdt_clear;
        logic psc_clear;
        logic [7:0] pins_meta;
        logic [7:0] pins_sync;
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_state_t;

endpackage

//--- risc_14bit_instruction_decoder.sv
// Instruction decoder and executor for a 14-bit word, 8-bit data core
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "risc14_cfg.svh"

// Functional notes
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - OR accumulator with file, zero flag
// - XOR accumulator with file, zero flag
// - Decrement file, skip on zero, no flags
// - Increment file, skip on zero, no flags
// - Bit test, skip when bit low
// - Bit test, skip when bit high
// - Add literal to accumulator, C DC Z
// - AND literal into accumulator, zero flag
// - OR literal into accumulator, zero flag
// - XOR literal into accumulator, zero flag
// - Literal minus accumulator, C DC Z
// - Load literal and return, two cycles
// - Subroutine return pops stack, two cycles
// - Handler return pops stack, two cycles
// - Standby entry updates timeout and powerdown
// - Watchdog kick updates timeout and powerdown
// - Port modify reads pin levels
// - Timer count write clears assigned prescaler
// - Branch or true test takes two cycles
// - Destination bit picks accumulator or file
// - One instruction cycle is four clocks
// - File address spans 0x00 to 0x7F
module risc_14bit_instruction_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    output logic [12:0] prog_addr,
    input wire logic [13:0] prog_word,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic wdt_clear,
    output logic prescaler_clear,
    output logic standby,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import risc14_pkg::*;

    risc14_pkg::core_state_t q;
    risc14_pkg::core_state_t n;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    // Decode fields, operands and results
    logic [13:0] iw;
    logic [1:0] grp;
    logic [3:0] op4;
    logic dsel;
    logic [6:0] fa;
    logic [2:0] bsel;
    logic [7:0] lit;
    logic [7:0] fval;
    logic [7:0] res;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic wr_res;
    logic wr_file;
    logic upd_z;
    logic upd_cdc;
    logic skip;
    logic branch;
    logic [12:0] target;
    logic [12:0] pc_inc;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    always_comb begin
        n = q;
        iw = prog_word;
        grp = iw[13:12];
        op4 = iw[11:8];
        dsel = iw[7];
        fa = iw[6:0];
        bsel = iw[9:7];
        lit = iw[7:0];
        fval = (fa == `FA_PORT) ? q.pins_sync : q.fregs[fa];
        res = 8'h00;
        sum9 = 9'h000;
        sum5 = 5'h00;
        wr_res = 1'b0;
        wr_file = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        skip = 1'b0;
        branch = 1'b0;
        target = q.pc;
        pc_inc = q.pc + 13'h0001;
        rd_word = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        n.wdt_clear = 1'b0;
        n.psc_clear = 1'b0;

        // Two-flop synchroniser for the port pins
        n.pins_meta = port_pins;
        n.pins_sync = q.pins_meta;

        // Phase counter: four clocks per instruction cycle
        if (q.mode == MODE_RUN) begin
            n.phase = q.phase + 2'h1;
        end else begin
            n.phase = 2'h0;
        end

        // Execute on the last phase of each instruction cycle
        if (q.mode == MODE_RUN && q.phase == `PHASE_EXEC) begin
            n.pc = pc_inc;
            n.nop_next = 1'b0;
            if (q.nop_next) begin
                n.pc = q.pc;
            end else begin
                case (grp)
                    `GRP_BYTE: begin
                        if (iw == `W_RETURN || iw == `W_RETURN_FROM_HANDLER) begin
                            n.sp = q.sp - 3'h1;
                            target = q.stack[n.sp];
                            branch = 1'b1;
                        end else if (iw == `W_SLEEP) begin
                            n.to = 1'b1;
                            n.pd = 1'b0;
                            n.wdt_clear = 1'b1;
                            n.mode = MODE_STANDBY;
                        end else if (iw == `W_KICK_WATCHDOG) begin
                            n.to = 1'b1;
                            n.pd = 1'b1;
                            n.wdt_clear = 1'b1;
                        end else begin
                            wr_res = 1'b1;
                            case (op4)
                                4'h0: begin
                                    // Move accumulator to file; other words no-op
                                    res = q.acc;
                                    wr_res = dsel;
                                    dsel = 1'b1;
                                end
                                4'h1: begin
                                    // Clear file or accumulator
                                    res = 8'h00;
                                    upd_z = 1'b1;
                                    wr_res = dsel || (iw == `W_CLRW);
                                end
                                4'h2: begin
                                    sum9 = {1'b0, fval} + {1'b0, ~q.acc} + 9'h001;
                                    sum5 = {1'b0, fval[3:0]} + {1'b0, ~q.acc[3:0]} + 5'h01;
                                    res = sum9[7:0];
                                    upd_z = 1'b1;
                                    upd_cdc = 1'b1;
                                end
                                4'h3: begin
                                    res = fval - 8'h01;
                                    upd_z = 1'b1;
                                end
                                4'h4: begin
                                    res = q.acc | fval;
                                    upd_z = 1'b1;
                                end
                                4'h5: begin
                                    res = q.acc & fval;
                                    upd_z = 1'b1;
                                end
                                4'h6: begin
                                    res = q.acc ^ fval;
                                    upd_z = 1'b1;
                                end
                                4'h7: begin
                                    sum9 = {1'b0, fval} + {1'b0, q.acc};
                                    sum5 = {1'b0, fval[3:0]} + {1'b0, q.acc[3:0]};
                                    res = sum9[7:0];
                                    upd_z = 1'b1;
                                    upd_cdc = 1'b1;
                                end
                                4'h8: begin
                                    res = fval;
                                    upd_z = 1'b1;
                                end
                                4'h9: begin
                                    res = ~fval;
                                    upd_z = 1'b1;
                                end
                                4'hA: begin
                                    res = fval + 8'h01;
                                    upd_z = 1'b1;
                                end
                                4'hB: begin
                                    res = fval - 8'h01;
                                    skip = (res == 8'h00);
                                end
                                4'hC: begin
                                    res = {q.c, fval[7:1]};
                                    n.c = fval[0];
                                end
                                4'hD: begin
                                    res = {fval[6:0], q.c};
                                    n.c = fval[7];
                                end
                                4'hE: begin
                                    res = {fval[3:0], fval[7:4]};
                                end
                                4'hF: begin
                                    res = fval + 8'h01;
                                    skip = (res == 8'h00);
                                end
                                default: begin
                                    wr_res = 1'b0;
                                end
                            endcase
                        end
                    end
                    `GRP_BIT: begin
                        res = fval;
                        case (op4[3:2])
                            2'h0: begin
                                res[bsel] = 1'b0;
                                wr_res = 1'b1;
                                dsel = 1'b1;
                            end
                            2'h1: begin
                                res[bsel] = 1'b1;
                                wr_res = 1'b1;
                                dsel = 1'b1;
                            end
                            2'h2: begin
                                skip = ~fval[bsel];
                            end
                            2'h3: begin
                                skip = fval[bsel];
                            end
                            default: begin
                                skip = 1'b0;
                            end
                        endcase
                    end
                    `GRP_JUMP: begin
                        // Call pushes the return address, jump does not
                        if (!op4[3]) begin
                            n.stack[q.sp] = pc_inc;
                            n.sp = q.sp + 3'h1;
                        end
                        target = {2'h0, iw[10:0]};
                        branch = 1'b1;
                    end
                    `GRP_LIT: begin
                        wr_res = 1'b1;
                        dsel = 1'b0;
                        case (op4)
                            4'h0, 4'h1, 4'h2, 4'h3: begin
                                res = lit;
                            end
                            4'h4, 4'h5, 4'h6, 4'h7: begin
                                res = lit;
                                n.sp = q.sp - 3'h1;
                                target = q.stack[n.sp];
                                branch = 1'b1;
                            end
                            4'h8: begin
                                res = q.acc | lit;
                                upd_z = 1'b1;
                            end
                            4'h9: begin
                                res = q.acc & lit;
                                upd_z = 1'b1;
                            end
                            4'hA: begin
                                res = q.acc ^ lit;
                                upd_z = 1'b1;
                            end
                            4'hC, 4'hD: begin
                                sum9 = {1'b0, lit} + {1'b0, ~q.acc} + 9'h001;
                                sum5 = {1'b0, lit[3:0]} + {1'b0, ~q.acc[3:0]} + 5'h01;
                                res = sum9[7:0];
                                upd_z = 1'b1;
                                upd_cdc = 1'b1;
                            end
                            4'hE, 4'hF: begin
                                sum9 = {1'b0, lit} + {1'b0, q.acc};
                                sum5 = {1'b0, lit[3:0]} + {1'b0, q.acc[3:0]};
                                res = sum9[7:0];
                                upd_z = 1'b1;
                                upd_cdc = 1'b1;
                            end
                            default: begin
                                wr_res = 1'b0;
                            end
                        endcase
                    end
                    default: begin
                        wr_res = 1'b0;
                    end
                endcase

                // Route the result by the destination bit
                wr_file = wr_res && dsel;
                if (wr_res && !dsel) begin
                    n.acc = res;
                end
                if (wr_file) begin
                    n.fregs[fa] = res;
                end
                // Timer count write restarts its prescaler when assigned
                if (wr_file && fa == `FA_TIMER0 && q.psa) begin
                    n.psc_clear = 1'b1;
                end
                // Only the listed flags move; all others hold
                if (upd_z) begin
                    n.z = (res == 8'h00);
                end
                if (upd_cdc) begin
                    n.c = sum9[8];
                    n.dc = sum5[4];
                end
                // Taken branch or true test burns a second cycle
                if (branch) begin
                    n.pc = target;
                    n.nop_next = 1'b1;
                end else if (skip) begin
                    n.pc = q.pc + 13'h0002;
                    n.nop_next = 1'b1;
                end
            end
        end

        // --------------------------------------------------------------------
        // Register bus write side
        // --------------------------------------------------------------------

        // Latch address and data in either order
        if (s_axi_awvalid && q.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Perform the write once both halves are held
        if (q.aw_got && q.w_got && !q.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            if ({q.aw_addr[3:2], 2'h0} == `OFS_CTRL) begin
                if (q.w_strb[0]) begin
                    n.mode = q.w_data[`CTRL_RUN_BIT] ? MODE_RUN : MODE_HALT;
                    if (q.mode == MODE_STANDBY && !q.w_data[`CTRL_WAKE_BIT]) begin
                        n.mode = MODE_STANDBY;
                    end
                    n.psa = q.w_data[`CTRL_PSA_BIT];
                end
            end else if ({q.aw_addr[3:2], 2'h0} != `OFS_STATUS
                         && {q.aw_addr[3:2], 2'h0} != `OFS_ACC) begin
                n.bresp = `RESP_SLVERR;
            end
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // --------------------------------------------------------------------
        // Register bus read side
        // --------------------------------------------------------------------
        case ({s_axi_araddr[3:2], 2'h0})
            `OFS_CTRL: begin
                rd_word[`CTRL_RUN_BIT] = (q.mode != MODE_HALT);
                rd_word[`CTRL_PSA_BIT] = q.psa;
            end
            `OFS_STATUS: begin
                rd_word[12:0] = q.pc;
                rd_word[`ST_C_BIT] = q.c;
                rd_word[`ST_DC_BIT] = q.dc;
                rd_word[`ST_Z_BIT] = q.z;
                rd_word[`ST_TO_BIT] = q.to;
                rd_word[`ST_PD_BIT] = q.pd;
                rd_word[`ST_MODE_LSB +: 2] = q.mode;
            end
            `OFS_ACC: begin
                rd_word[7:0] = q.acc;
            end
            default: begin
                rd_resp = `RESP_SLVERR;
            end
        endcase
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word;
            n.rresp = rd_resp;
        end
        n.arready = !n.rvalid;
    end

    // ------------------------------------------------------------------------
    // State register, frozen while the clock enable is low
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.pc <= `RST_PC;
            q.to <= 1'b1;
            q.pd <= 1'b1;
            q.mode <= MODE_HALT;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else if (clk_en) begin
            q <= n;
        end
    end

    // Outputs taken straight from the state register
    assign prog_addr = q.pc;
    assign port_latch = q.fregs[`FA_PORT];
    assign wdt_clear = q.wdt_clear;
    assign prescaler_clear = q.psc_clear;
    assign standby = (q.mode == MODE_STANDBY);
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule

//--- risc14_assertions.sv
// Port assertions for the 14-bit instruction decoder
`timescale 1ns/1ns
`include "risc14_cfg.svh"
module risc14_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [12:0] prog_addr,
    input wire logic [13:0] prog_word,
    input wire logic wdt_clear,
    input wire logic prescaler_clear,
    input wire logic standby
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // Execution flow and side pulses
    // ----
    property p_cyc; $changed(prog_addr) |=> $stable(prog_addr) [*3]; endproperty
    a_cyc: assert property (p_cyc) else $error("fetch moved early");
    property p_ret;
        $changed(prog_addr) && ($past(prog_word) inside {`W_RETURN, `W_RETURN_FROM_HANDLER}
            || $past(prog_word[13:10]) == 4'hD) |=> $stable(prog_addr) [*7];
    endproperty
    a_ret: assert property (p_ret) else $error("return not two cycles");
    property p_lit;
        $changed(prog_addr) && $past(prog_word[13:12]) == `GRP_LIT
            && $past(prog_word[11:10]) != 2'h1 |-> prog_addr == $past(prog_addr) + 13'h1;
    endproperty
    a_lit: assert property (p_lit) else $error("literal op not one cycle");
    property p_unk;
        $changed(prog_addr) && $past(prog_word) == 14'h0001
            |-> prog_addr == $past(prog_addr) + 13'h1;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown word not a no-op");
    property p_skp;
        $changed(prog_addr) && ($past(prog_word[13:11]) == 3'h3
            || $past(prog_word[13:8]) inside {6'h0B, 6'h0F})
            |-> prog_addr == $past(prog_addr) + 13'h1
            or prog_addr == $past(prog_addr) + 13'h2 ##1 $stable(prog_addr) [*7];
    endproperty
    a_skp: assert property (p_skp) else $error("bad skip");
    property p_wdt;
        wdt_clear |-> $past(prog_word) inside {`W_KICK_WATCHDOG, `W_SLEEP} ##1 !wdt_clear;
    endproperty
    a_wdt: assert property (p_wdt) else $error("bad watchdog pulse");
    property p_slp; $rose(standby) |-> wdt_clear && $past(prog_word) == `W_SLEEP; endproperty
    a_slp: assert property (p_slp) else $error("bad standby entry");
    property p_psc;
        prescaler_clear |-> $past(prog_word[6:0]) == `FA_TIMER0 ##1 !prescaler_clear;
    endproperty
    a_psc: assert property (p_psc) else $error("bad prescaler pulse");
    c_slp: cover property (standby);
    c_psc: cover property (prescaler_clear);
    c_ret: cover property ($changed(prog_addr) && $past(prog_word) == `W_RETURN);
endmodule
bind risc_14bit_instruction_decoder risc14_assertions i_risc14_assertions (.*);

//--- prog_rom_model.sv
// Program memory model feeding instruction words to the decoder
`timescale 1ns/1ns
module prog_rom_model (
    input wire logic [12:0] prog_addr,
    output logic [13:0] prog_word
);
    // ----
    // Word store, loaded by the bench; unused words trap in a self-jump
    // ----
    logic [13:0] mem [0:31];
    initial foreach (mem[i]) mem[i] = 14'h281F;
    // Same-cycle read of the addressed word
    assign prog_word = mem[prog_addr[4:0]];
endmodule

//--- risc_14bit_instruction_decoder_test.sv
// Self-checking bench for the 14-bit instruction decoder
`timescale 1ns/1ns
`include "risc14_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module risc_14bit_instruction_decoder_test;
    logic aclk = '0, aresetn = '0, clk_en = '1, wdt_clear, prescaler_clear, standby;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rresp;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdata;
    logic [7:0] port_pins = 8'h0F, port_latch;
    logic [12:0] prog_addr;
    logic [13:0] prog_word;
    int num_errors = 0, n_checks = 0, n_wdt = 0, n_psc = 0;
    // ----
    // Design, program memory, clock and bus tasks
    // ----
    risc_14bit_instruction_decoder i_risc_14bit_instruction_decoder (.*);
    prog_rom_model i_prog_rom_model (.prog_addr(prog_addr), .prog_word(prog_word));
    initial forever #4 aclk = ~aclk;
    // Count watchdog and prescaler pulses while out of reset
    always @(posedge aclk) begin
        n_wdt <= n_wdt + int'(aresetn && wdt_clear);
        n_psc <= n_psc + int'(aresetn && prescaler_clear);
    end
    // One clock of a bounded wait; a hang counts as a mismatch
    task automatic step(inout int n);
        @(posedge aclk);
        if (++n > 300) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do begin
            step(n);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        `CHK(s_axi_bresp, `RESP_OKAY)
        s_axi_bready <= '0;
    endtask
    task automatic rd(input logic [3:0] a);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do begin
            step(n);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        rdata = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= '0;
    endtask
    // Load a program, reset, start the core and wait for its final address
    task automatic run(input logic [13:0] w [14], input logic [31:0] ctrl, input logic [12:0] fin);
        int n = 0;
        @(posedge aclk);
        aresetn <= '0;
        foreach (w[i]) i_prog_rom_model.mem[i] = w[i];
        repeat (6) @(posedge aclk);
        aresetn <= '1;
        wr(`OFS_CTRL, ctrl);
        do step(n); while (prog_addr !== fin);
    endtask
    task automatic lit_ops;
        run('{14'h30F0, 14'h3E20, 14'h3917, 14'h3803, 14'h3A1F, 14'h3C05, 14'h2806,
            14'h0, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0}, 32'h1, 13'h6);
        rd(`OFS_ACC);
        `CHK(rdata, 32'hF9)
        rd(`OFS_STATUS);
        `CHK(rdata[22:16], 7'h38)
    endtask
    // Skipped words jump to the trap, so reaching the end proves each skip
    task automatic file_ops;
        run('{14'h3C01, 14'h00A0, 14'h0BA0, 14'h281F, 14'h0F20, 14'h04A0, 14'h0620,
            14'h0DA0, 14'h1CA0, 14'h281F, 14'h1920, 14'h281F, 14'h0C20, 14'h280D}, 32'h1, 13'hD);
        rd(`OFS_ACC);
        `CHK(rdata, 32'h01)
        rd(`OFS_STATUS);
        `CHK(rdata[22:16], 7'h3F)
        `CHK(rdata[12:0], 13'hD)
    endtask
    task automatic flow_ops;
        run('{14'h305A, 14'h0086, 14'h0486, 14'h0081, 14'h0064, 14'h0001, 14'h2009,
            14'h0063, 14'h0, 14'h200B, 14'h0008, 14'h200D, 14'h0009, 14'h3433}, 32'h3, 13'h8);
        `CHK(port_latch, 8'h5F)
        `CHK(standby, 1'h1)
        rd(`OFS_ACC);
        `CHK(rdata, 32'h33)
        `CHK(n_wdt, 2)
        `CHK(n_psc, 1)
        rd(`OFS_STATUS);
        `CHK(rdata[22:19], 4'h9)
        rd(4'hC);
        `CHK(rresp, `RESP_SLVERR)
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        lit_ops();
        file_ops();
        flow_ops();
        finish_test();
    end
endmodule
